// *** common/ep_irq_consts.svh ***
`ifndef EP_IRQ_CONSTS_SVH
`define EP_IRQ_CONSTS_SVH
`define SFR_EP_IRQ_ENABLE 8'hC2
`define SFR_EP_FIFO_DATA 8'hCF
`define SFR_EP_IRQ_FLAGS 8'hF8
`define SFR_EP_SELECT 8'hC7
`define EP_IRQ_RESET 4'h0
`define EP_COUNT 4
`define EP_FIFO_DEPTH 8
`define EP_PTR_W 3
`endif

// *** common/ep_irq_pkg.sv ***
package ep_irq_pkg;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfr_req_t;
	typedef enum logic [1:0] {
		ACC_IDLE = 2'b01,
		ACC_BUSY = 2'b10
	} acc_state_t;
endpackage

// *** design/ep_fifo_store.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "ep_irq_consts.svh"
// eight byte FIFO per endpoint, flip-flop storage
module ep_fifo_store (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic [1:0] sel_in,
	input wire logic push_in,
	input wire logic pop_in,
	input wire logic [7:0] wdata_in,
	output logic [7:0] rdata_out
);
	logic [7:0] mem_r [`EP_COUNT][`EP_FIFO_DEPTH];
	logic [`EP_PTR_W-1:0] wp_r [`EP_COUNT];
	logic [`EP_PTR_W-1:0] rp_r [`EP_COUNT];

	always_ff @(posedge core_clk_in) begin
		if (push_in) begin
			mem_r[sel_in][wp_r[sel_in]] <= wdata_in;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			for (int i = 0; i < `EP_COUNT; i++) begin
				wp_r[i] <= '0;
				rp_r[i] <= '0;
			end
		end else begin
			if (push_in) begin
				wp_r[sel_in] <= wp_r[sel_in] + 1'b1;
			end
			if (pop_in) begin
				rp_r[sel_in] <= rp_r[sel_in] + 1'b1;
			end
		end
	end

	assign rdata_out = mem_r[sel_in][rp_r[sel_in]];
endmodule
`default_nettype wire

// *** design/ep_irq_fifo_port.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "ep_irq_consts.svh"
module ep_irq_fifo_port
	import ep_irq_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic sfr_wr_in,
	input wire logic sfr_rd_in,
	input wire logic [7:0] sfr_addr_in,
	input wire logic [7:0] sfr_wdata_in,
	input wire logic [3:0] ep_event_in,
	output logic [7:0] sfr_rdata_out,
	output logic usb_irq_out
);
	sfr_req_t req;
	logic [3:0] flag_r, flag_nxt;
	logic [3:0] enable_r;
	logic [1:0] select_r;
	logic [7:0] rdata_r;
	logic [7:0] fifo_rdata;
	logic fifo_push, fifo_pop;

	assign req = '{wr: sfr_wr_in, rd: sfr_rd_in, addr: sfr_addr_in,
		wdata: sfr_wdata_in};

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	assign fifo_push = req.wr && hit(req.addr, `SFR_EP_FIFO_DATA);
	assign fifo_pop = req.rd && hit(req.addr, `SFR_EP_FIFO_DATA);

	ep_fifo_store u_fifo (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.sel_in(select_r),
		.push_in(fifo_push),
		.pop_in(fifo_pop),
		.wdata_in(req.wdata),
		.rdata_out(fifo_rdata)
	);

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			enable_r <= `EP_IRQ_RESET;
		end else if (req.wr && hit(req.addr, `SFR_EP_IRQ_ENABLE)) begin
			enable_r <= req.wdata[3:0];
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			select_r <= 2'h0;
		end else if (req.wr && hit(req.addr, `SFR_EP_SELECT)) begin
			select_r <= req.wdata[1:0];
		end
	end

	// clear by writing zero to a set flag; a new event wins over the clear
	always_comb begin
		flag_nxt = flag_r;
		if (req.wr && hit(req.addr, `SFR_EP_IRQ_FLAGS)) begin
			flag_nxt = flag_r & req.wdata[3:0];
		end
		flag_nxt = flag_nxt | (ep_event_in & enable_r);
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			flag_r <= `EP_IRQ_RESET;
		end else begin
			flag_r <= flag_nxt;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			rdata_r <= 8'h00;
		end else if (req.rd) begin
			case (req.addr)
				`SFR_EP_IRQ_FLAGS: rdata_r <= {4'h0, flag_r};
				`SFR_EP_IRQ_ENABLE: rdata_r <= {4'h0, enable_r};
				`SFR_EP_SELECT: rdata_r <= {6'h00, select_r};
				`SFR_EP_FIFO_DATA: rdata_r <= fifo_rdata;
				default: rdata_r <= 8'h00;
			endcase
		end
	end

	assign sfr_rdata_out = rdata_r;
	assign usb_irq_out = |flag_r;

	sticky_set_a: assert property (@(posedge core_clk_in)
		disable iff (rst_in)
		(ep_event_in[0] && enable_r[0]) |=> flag_r[0])
		else $error("enabled event did not set flag");

	masked_evt_a: assert property (@(posedge core_clk_in)
		disable iff (rst_in)
		(!flag_r[1] && !enable_r[1] &&
		!(req.wr && req.addr == `SFR_EP_IRQ_FLAGS)) |=> !flag_r[1])
		else $error("disabled event set flag");

	flag_hold_a: assert property (@(posedge core_clk_in)
		disable iff (rst_in)
		(flag_r[2] && !(req.wr && req.addr == `SFR_EP_IRQ_FLAGS))
		|=> flag_r[2])
		else $error("flag cleared without software");

	irq_level_a: assert property (@(posedge core_clk_in)
		disable iff (rst_in)
		usb_irq_out == (flag_r != 4'h0))
		else $error("irq does not track flags");

	rsvd_zero_a: assert property (@(posedge core_clk_in)
		disable iff (rst_in)
		(req.rd && (req.addr == `SFR_EP_IRQ_FLAGS ||
		req.addr == `SFR_EP_IRQ_ENABLE)) |=> sfr_rdata_out[7:4] == 4'h0)
		else $error("reserved bits read nonzero");

	reset_zero_a: assert property (@(posedge core_clk_in)
		rst_in |=> (flag_r == 4'h0 && enable_r == 4'h0))
		else $error("registers not zero after reset");

	enable_wr_a: assert property (@(posedge core_clk_in)
		disable iff (rst_in)
		(req.wr && req.addr == `SFR_EP_IRQ_ENABLE) |=>
		enable_r == $past(req.wdata[3:0]))
		else $error("enable write lost");

	no_soft_set_a: assert property (@(posedge core_clk_in)
		disable iff (rst_in)
		(!flag_r[3] && !ep_event_in[3]) |=> !flag_r[3])
		else $error("flag set without event");

	fifo_rd_a: assert property (@(posedge core_clk_in)
		disable iff (rst_in)
		fifo_pop |=> sfr_rdata_out == $past(fifo_rdata))
		else $error("data read wrong byte");

	irq_event_a: assert property (@(posedge core_clk_in)
		disable iff (rst_in)
		(ep_event_in & enable_r) != 4'h0 |=> usb_irq_out)
		else $error("enabled event did not raise irq");

	flag_clear_a: assert property (@(posedge core_clk_in)
		disable iff (rst_in)
		(req.wr && req.addr == `SFR_EP_IRQ_FLAGS && !req.wdata[0] &&
		!(ep_event_in[0] && enable_r[0])) |=> !flag_r[0])
		else $error("flag clear write lost");

	flag_keep_a: assert property (@(posedge core_clk_in)
		disable iff (rst_in)
		(req.wr && req.addr == `SFR_EP_IRQ_FLAGS && req.wdata[1] &&
		flag_r[1]) |=> flag_r[1])
		else $error("writing one cleared a flag");

	set_wins_a: assert property (@(posedge core_clk_in)
		disable iff (rst_in)
		(ep_event_in[2] && enable_r[2] && req.wr &&
		req.addr == `SFR_EP_IRQ_FLAGS) |=> flag_r[2])
		else $error("clear beat a same cycle event");

	gated_set_a: assert property (@(posedge core_clk_in)
		disable iff (rst_in)
		1'b1 |=> (flag_r & ~$past(flag_r) &
		~$past(ep_event_in & enable_r)) == 4'h0)
		else $error("flag rose without enabled event");

	sel_wr_a: assert property (@(posedge core_clk_in)
		disable iff (rst_in)
		(req.wr && req.addr == `SFR_EP_SELECT) |=>
		select_r == $past(req.wdata[1:0]))
		else $error("selector write lost");

	flags_rd_a: assert property (@(posedge core_clk_in)
		disable iff (rst_in)
		(req.rd && req.addr == `SFR_EP_IRQ_FLAGS) |=>
		sfr_rdata_out == {4'h0, $past(flag_r)})
		else $error("flag read wrong value");

	enable_rd_a: assert property (@(posedge core_clk_in)
		disable iff (rst_in)
		(req.rd && req.addr == `SFR_EP_IRQ_ENABLE) |=>
		sfr_rdata_out == {4'h0, $past(enable_r)})
		else $error("enable read wrong value");

	rdata_hold_a: assert property (@(posedge core_clk_in)
		disable iff (rst_in)
		!req.rd |=> $stable(sfr_rdata_out))
		else $error("read data changed without a read");

	irq_drop_a: assert property (@(posedge core_clk_in)
		disable iff (rst_in)
		(req.wr && req.addr == `SFR_EP_IRQ_FLAGS &&
		req.wdata[3:0] == 4'h0 && ep_event_in == 4'h0) |=> !usb_irq_out)
		else $error("irq stayed high after clear");

	unmapped_rd_a: assert property (@(posedge core_clk_in)
		disable iff (rst_in)
		(req.rd && req.addr != `SFR_EP_IRQ_FLAGS &&
		req.addr != `SFR_EP_IRQ_ENABLE && req.addr != `SFR_EP_SELECT &&
		req.addr != `SFR_EP_FIFO_DATA) |=> sfr_rdata_out == 8'h00)
		else $error("unmapped read nonzero");

	irq_raise_c: cover property (@(posedge core_clk_in) $rose(usb_irq_out));
	irq_clear_c: cover property (@(posedge core_clk_in) $fell(usb_irq_out));
	push_pop_c: cover property (@(posedge core_clk_in)
		fifo_push ##[1:8] fifo_pop);
	set_clear_c: cover property (@(posedge core_clk_in)
		(ep_event_in & enable_r) != 4'h0 && req.wr &&
		req.addr == `SFR_EP_IRQ_FLAGS);
	sel_pop_c: cover property (@(posedge core_clk_in)
		(req.wr && req.addr == `SFR_EP_SELECT) ##[1:4] fifo_pop);
endmodule
`default_nettype wire

// *** sim/ep_event_src.sv ***
`timescale 1ns/1ns
`default_nettype none
// usb side: endpoint status events as one-cycle pulses
module ep_event_src (
	input wire logic core_clk_in,
	output logic [3:0] ev_out
);
	initial begin
		ev_out = 4'h0;
	end
	task automatic pulse(input logic [3:0] m);
		@(negedge core_clk_in);
		ev_out = m;
		@(negedge core_clk_in);
		ev_out = 4'h0;
	endtask
endmodule
`default_nettype wire

// *** sim/tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin mismatches++; \
$display("unexpected %s exp %h got %h", n, e, s); end end
module tb;
	import ep_irq_pkg::*;
	logic core_clk_in = 1'h0;
	logic rst_in = 1'h1;
	sfr_req_t req = '0;
	logic [3:0] ev;
	logic [3:0] e;
	logic [7:0] rdata, b, m;
	logic irq;
	int mismatches = 0;
	int n_tests = 0;
	logic [7:0] q[4][$];
	ep_irq_fifo_port u_ep_irq_fifo_port (.core_clk_in(core_clk_in),
		.rst_in(rst_in), .sfr_wr_in(req.wr), .sfr_rd_in(req.rd),
		.sfr_addr_in(req.addr), .sfr_wdata_in(req.wdata),
		.ep_event_in(ev), .sfr_rdata_out(rdata), .usb_irq_out(irq));
	ep_event_src u_ep_event_src (.core_clk_in(core_clk_in), .ev_out(ev));
	function automatic logic [7:0] fexp(logic [7:0] en, logic [3:0] x);
		return {4'h0, en[3:0] & x};
	endfunction
	task automatic close_out;
		if (mismatches == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk_in);
		req = '{wr: w, rd: !w, addr: a, wdata: d};
		@(negedge core_clk_in);
		req = '0;
		@(negedge core_clk_in);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] x, input string n);
		acc(1'h0, a, 8'h00);
		`CHK(n, x, rdata)
	endtask
	initial begin
		forever #5 core_clk_in = ~core_clk_in;
	end
	initial begin
		#200000;
		mismatches++;
		close_out;
	end
	initial begin
		void'($urandom(28));
		repeat (16) @(negedge core_clk_in);
		rst_in = 1'h0;
		rd(8'hC2, 8'h00, "enable");
		rd(8'hF8, 8'h00, "flags");
		for (int i = 0; i < 8; i++) begin
			m = (i == 0) ? 8'h0F : {4'h0, 4'($urandom)};
			e = (i == 1) ? 4'hF : 4'($urandom);
			acc(1'h1, 8'hC2, m);
			rd(8'hC2, m, "enable");
			u_ep_event_src.pulse(e);
			rd(8'hF8, fexp(m, e), "flags");
			`CHK("irq", |fexp(m, e), irq)
			acc(1'h1, 8'hF8, 8'h0F);
			repeat (4) @(negedge core_clk_in);
			rd(8'hF8, fexp(m, e), "sticky");
			acc(1'h1, 8'hF8, 8'h00);
			rd(8'hF8, 8'h00, "cleared");
			`CHK("irq off", 1'h0, irq)
		end
		acc(1'h1, 8'hC2, 8'h0F);
		fork
			acc(1'h1, 8'hF8, 8'h00);
			u_ep_event_src.pulse(4'h5);
		join
		rd(8'hF8, 8'h05, "set wins");
		`CHK("irq set", 1'h1, irq)
		acc(1'h1, 8'h55, 8'h00);
		rd(8'hC2, 8'h0F, "unmapped wr");
		acc(1'h1, 8'hC2, 8'h00);
		u_ep_event_src.pulse(4'hF);
		rd(8'hF8, 8'h05, "masked");
		acc(1'h1, 8'hF8, 8'h00);
		rd(8'hF8, 8'h00, "cleared all");
		for (int i = 0; i < 16; i++) begin
			b = 8'($urandom);
			acc(1'h1, 8'hC7, {6'h00, i[1:0]});
			acc(1'h1, 8'hCF, b);
			q[i[1:0]].push_back(b);
		end
		for (int k = 3; k >= 0; k--) begin
			acc(1'h1, 8'hC7, 8'(k));
			for (int j = 0; j < q[k].size(); j++) begin
				rd(8'hCF, q[k][j], "fifo");
			end
			rd(8'hC7, 8'(k), "select");
		end
		rd(8'h55, 8'h00, "unmapped");
		close_out;
	end
endmodule
`default_nettype wire
